// ### rtc_far_end.sv
// far side model: field-bus frame pulses and the range-valid pin
// assumes one clock shared with the block
module rtc_far_end (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic link_on,
  input  wire logic range_want,
  output logic      link_rx,
  output logic      range_ok_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] gap_ff;
  initial begin
    gap_ff = 4'h0;
    link_rx = 1'b0;
    range_ok_pin = 1'b1;
  end
  // a frame every sixteen cycles keeps the link alive
  always @(posedge ref_clk) begin
    gap_ff <= sys_rst ? 4'h0 : gap_ff + 4'h1;
    link_rx <= link_on && !sys_rst && gap_ff == 4'hf;
    range_ok_pin <= range_want;
  end
endmodule // rtc_far_end

// ### rtc_pkg.sv
// holds constants and types for the relay threshold control
// assumes one 125 MHz clock and a plain register port from software
package rtc_pkg;

  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned TENTH_SEC_NS  = 100_000_000;
  localparam int unsigned CLK_NS        = 8;
  localparam int unsigned TENTH_CYCLES  = TENTH_SEC_NS / CLK_NS;
  localparam int unsigned MIN_PER_SEC   = 60;
  localparam int unsigned DLY_MAX       = 999;
  localparam int unsigned VAL_W         = 16;
  localparam int unsigned DLY_W         = 10;
  localparam int unsigned TMO_W         = 16;

  localparam logic [3:0] A_MEAS   = 4'h0;
  localparam logic [3:0] A_THR1   = 4'h1;
  localparam logic [3:0] A_THR2   = 4'h2;
  localparam logic [3:0] A_HYSTERESIS_WIDTH   = 4'h3;
  localparam logic [3:0] A_CTRL   = 4'h4;
  localparam logic [3:0] A_TON    = 4'h5;
  localparam logic [3:0] A_TURN_OFF_DELAY   = 4'h6;
  localparam logic [3:0] A_TMO    = 4'h7;
  localparam logic [3:0] A_BUSCMD = 4'h8;
  localparam logic [3:0] A_STAT   = 4'h9;
  localparam logic [3:0] A_IRQ_ST = 4'ha;
  localparam logic [3:0] A_IRQ_EN = 4'hb;
  localparam logic [3:0] A_IRQ_CL = 4'hc;

  // control register field positions
  localparam int unsigned F_MODE_LO  = 0;
  localparam int unsigned F_FAULT_LO = 3;
  localparam int unsigned F_UNIT_MIN = 5;
  localparam int unsigned F_RANGE_OK = 6;

  localparam logic [2:0] M_DIS = 3'h0;
  localparam logic [2:0] M_ON  = 3'h1;
  localparam logic [2:0] M_OFF = 3'h2;
  localparam logic [2:0] M_IN  = 3'h3;
  localparam logic [2:0] M_OUT = 3'h4;
  localparam logic [2:0] M_BUS = 3'h5;

  localparam logic [1:0] FR_HOLD = 2'h0;
  localparam logic [1:0] FR_ON   = 2'h1;
  localparam logic [1:0] FR_OFF  = 2'h2;

  localparam int unsigned IRQ_W  = 3;
  localparam int unsigned I_ON   = 0;
  localparam int unsigned I_OFF  = 1;
  localparam int unsigned I_CRIT = 2;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rtc_bus_req_t;

  typedef struct packed {
    logic [2:0]  mode;
    logic [1:0]  fault;
    logic        unit_min;
  } rtc_cfg_t;

endpackage : rtc_pkg

// ### rtc_relay.sv
// relay threshold decision, delays, fault reaction, register port, interrupt
// assumes the register port and bus-frame strobe come from ref_clk logic;
// the range-valid flag comes from a pin and is synchronised here
module rtc_relay (
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  input  wire rtc_pkg::rtc_bus_req_t bus_req,
  output logic [31:0]             rd_data,
  input  wire logic               range_ok_pin,
  input  wire logic               link_rx,
  output logic                    relay_coil,
  output logic                    relay_led,
  output logic                    irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic signed [rtc_pkg::VAL_W-1:0] meas_ff;
  logic signed [rtc_pkg::VAL_W-1:0] first_threshold_ff;
  logic signed [rtc_pkg::VAL_W-1:0] second_threshold_ff;
  logic signed [rtc_pkg::VAL_W-1:0] hysteresis_width_ff;
  rtc_pkg::rtc_cfg_t                cfg_ff;
  logic [rtc_pkg::DLY_W-1:0]        turn_on_delay_ff;
  logic [rtc_pkg::DLY_W-1:0]        turn_off_delay_ff;
  logic [rtc_pkg::TMO_W-1:0]        link_silence_timeout_ff;
  logic                             bus_cmd_ff;
  logic [rtc_pkg::IRQ_W-1:0]        irq_st_ff;
  logic [rtc_pkg::IRQ_W-1:0]        irq_en_ff;
  logic [1:0]                       rng_sync_ff;
  logic                             crit_ff;

  wire logic wr = clk_en & bus_req.wr;
  wire logic rd = clk_en & bus_req.rd;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // in-range idle level, so no false critical edge follows reset
      rng_sync_ff <= '1;
    end else if (clk_en) begin
      rng_sync_ff <= {rng_sync_ff[0], range_ok_pin};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meas_ff                 <= '0;
      first_threshold_ff      <= '0;
      second_threshold_ff     <= '0;
      hysteresis_width_ff     <= '0;
      cfg_ff                  <= '{mode: rtc_pkg::M_DIS,
                                   fault: rtc_pkg::FR_HOLD,
                                   unit_min: 1'b0};
      turn_on_delay_ff        <= '0;
      turn_off_delay_ff       <= '0;
      link_silence_timeout_ff <= '0;
    end else if (wr) begin
      unique case (bus_req.addr)
        rtc_pkg::A_MEAS:
          meas_ff <= bus_req.wdata[rtc_pkg::VAL_W-1:0];
        rtc_pkg::A_THR1:
          first_threshold_ff <= bus_req.wdata[rtc_pkg::VAL_W-1:0];
        rtc_pkg::A_THR2:
          second_threshold_ff <= bus_req.wdata[rtc_pkg::VAL_W-1:0];
        rtc_pkg::A_HYSTERESIS_WIDTH:
          hysteresis_width_ff <= bus_req.wdata[rtc_pkg::VAL_W-1:0];
        rtc_pkg::A_CTRL: begin
          cfg_ff.mode     <= bus_req.wdata[rtc_pkg::F_MODE_LO +: 3];
          cfg_ff.fault    <= bus_req.wdata[rtc_pkg::F_FAULT_LO +: 2];
          cfg_ff.unit_min <= bus_req.wdata[rtc_pkg::F_UNIT_MIN];
        end
        rtc_pkg::A_TON:
          turn_on_delay_ff <= clamp_dly(bus_req.wdata[rtc_pkg::DLY_W-1:0]);
        rtc_pkg::A_TURN_OFF_DELAY:
          turn_off_delay_ff <= clamp_dly(bus_req.wdata[rtc_pkg::DLY_W-1:0]);
        rtc_pkg::A_TMO:
          link_silence_timeout_ff <= bus_req.wdata[rtc_pkg::TMO_W-1:0];
        default: ;
      endcase
    end
  end

  function automatic logic [rtc_pkg::DLY_W-1:0] clamp_dly(
    input logic [rtc_pkg::DLY_W-1:0] v
  );
    if (v > rtc_pkg::DLY_W'(rtc_pkg::DLY_MAX)) begin
      return rtc_pkg::DLY_W'(rtc_pkg::DLY_MAX);
    end
    return v;
  endfunction

  // bus commanded state is volatile: reset clears it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_cmd_ff <= 1'b0;
    end else if (wr && bus_req.addr == rtc_pkg::A_BUSCMD) begin
      bus_cmd_ff <= bus_req.wdata[0];
    end
  end

  // ----------------------------------------------------------------
  // zone decision
  // ----------------------------------------------------------------
  logic signed [rtc_pkg::VAL_W:0] lo_thr;
  logic signed [rtc_pkg::VAL_W:0] hi_thr;
  logic signed [rtc_pkg::VAL_W:0] t1_x;
  logic signed [rtc_pkg::VAL_W:0] m_x;
  logic signed [rtc_pkg::VAL_W:0] h_x;
  logic                           want_on;
  logic                           want_off;

  // widen by one sign bit so threshold plus hysteresis cannot wrap
  function automatic logic signed [rtc_pkg::VAL_W:0] sx(
    input logic signed [rtc_pkg::VAL_W-1:0] v
  );
    return {v[rtc_pkg::VAL_W-1], v};
  endfunction

  always_comb begin
    m_x  = sx(meas_ff);
    h_x  = sx(hysteresis_width_ff);
    t1_x = sx(first_threshold_ff);
    if (first_threshold_ff < second_threshold_ff) begin
      lo_thr = t1_x;
      hi_thr = sx(second_threshold_ff);
    end else begin
      lo_thr = sx(second_threshold_ff);
      hi_thr = t1_x;
    end
    want_on  = 1'b0;
    want_off = 1'b0;
    unique case (cfg_ff.mode)
      rtc_pkg::M_ON: begin
        want_on  = m_x > t1_x + h_x;
        want_off = m_x < t1_x - h_x;
      end
      rtc_pkg::M_OFF: begin
        want_off = m_x > t1_x + h_x;
        want_on  = m_x < t1_x - h_x;
      end
      rtc_pkg::M_IN: begin
        want_on  = (m_x > lo_thr + h_x) && (m_x < hi_thr - h_x);
        want_off = (m_x < lo_thr - h_x) || (m_x > hi_thr + h_x);
      end
      rtc_pkg::M_OUT: begin
        want_on  = (m_x > hi_thr + h_x) || (m_x < lo_thr - h_x);
        want_off = (m_x > lo_thr + h_x) && (m_x < hi_thr - h_x);
      end
      default: begin
        want_on  = 1'b0;
        want_off = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // time base: tenths of the chosen unit
  // ----------------------------------------------------------------
  logic [23:0] pre_ff;
  logic [5:0]  sec_ff;
  logic        tick_ff;
  wire logic   pre_end = pre_ff == 24'(rtc_pkg::TENTH_CYCLES - 1);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pre_ff  <= '0;
      sec_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (clk_en) begin
      pre_ff  <= pre_end ? 24'h0 : pre_ff + 24'h1;
      tick_ff <= 1'b0;
      if (pre_end) begin
        // minute mode ticks once per sixty tenths, a tenth of a minute
        if (!cfg_ff.unit_min) begin
          tick_ff <= 1'b1;
        end else if (sec_ff == 6'(rtc_pkg::MIN_PER_SEC - 1)) begin
          sec_ff  <= 6'h0;
          tick_ff <= 1'b1;
        end else begin
          sec_ff <= sec_ff + 6'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // link silence watchdog, counts tenths of a second with no frames
  // ----------------------------------------------------------------
  logic [rtc_pkg::TMO_W-1:0] sil_ff;
  logic                      sil_crit;
  assign sil_crit = sil_ff > link_silence_timeout_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sil_ff <= '0;
    end else if (clk_en) begin
      if (link_rx) begin
        sil_ff <= '0;
      // stops once critical so the count cannot wrap back to quiet
      end else if (pre_end && !sil_crit) begin
        sil_ff <= sil_ff + 16'h1;
      end
    end
  end

  logic crit_now;
  always_comb begin
    if (cfg_ff.mode == rtc_pkg::M_BUS) begin
      crit_now = sil_crit;
    end else if (cfg_ff.mode == rtc_pkg::M_DIS) begin
      // range loss still counts here so a force-on reaction can act
      crit_now = !rng_sync_ff[1];
    end else begin
      crit_now = !rng_sync_ff[1];
    end
  end

  // ----------------------------------------------------------------
  // delayed switching and fault reaction
  // ----------------------------------------------------------------
  logic [rtc_pkg::DLY_W-1:0] dly_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      relay_coil <= 1'b0;
      relay_led  <= 1'b0;
      dly_ff     <= '0;
      crit_ff    <= 1'b0;
    end else if (clk_en) begin
      crit_ff <= crit_now;
      if (crit_now && cfg_ff.fault == rtc_pkg::FR_ON) begin
        relay_coil <= 1'b1;
        relay_led  <= 1'b1;
        dly_ff     <= '0;
      end else if (crit_now && cfg_ff.fault == rtc_pkg::FR_OFF) begin
        relay_coil <= 1'b0;
        relay_led  <= 1'b0;
        dly_ff     <= '0;
      end else if (crit_now) begin
        dly_ff <= '0;
      end else if (cfg_ff.mode == rtc_pkg::M_DIS) begin
        relay_coil <= 1'b0;
        relay_led  <= 1'b0;
        dly_ff     <= '0;
      end else if (cfg_ff.mode == rtc_pkg::M_BUS) begin
        relay_coil <= bus_cmd_ff;
        relay_led  <= bus_cmd_ff;
        dly_ff     <= '0;
      end else if (!relay_coil && want_on) begin
        if (dly_ff >= turn_on_delay_ff) begin
          relay_coil <= 1'b1;
          relay_led  <= 1'b1;
          dly_ff     <= '0;
        end else if (tick_ff) begin
          dly_ff <= dly_ff + 10'h1;
        end
      end else if (relay_coil && want_off) begin
        if (dly_ff >= turn_off_delay_ff) begin
          relay_coil <= 1'b0;
          relay_led  <= 1'b0;
          dly_ff     <= '0;
        end else if (tick_ff) begin
          dly_ff <= dly_ff + 10'h1;
        end
      end else begin
        dly_ff <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupts: set wins over clear
  // ----------------------------------------------------------------
  logic [rtc_pkg::IRQ_W-1:0] ev;
  logic                      coil_d_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      coil_d_ff <= 1'b0;
    end else if (clk_en) begin
      coil_d_ff <= relay_coil;
    end
  end

  always_comb begin
    ev = '0;
    ev[rtc_pkg::I_ON]   = relay_coil & ~coil_d_ff;
    ev[rtc_pkg::I_OFF]  = ~relay_coil & coil_d_ff;
    ev[rtc_pkg::I_CRIT] = crit_now & ~crit_ff;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_st_ff <= '0;
      irq_en_ff <= '0;
      irq       <= 1'b0;
    end else if (clk_en) begin
      if (wr && bus_req.addr == rtc_pkg::A_IRQ_EN) begin
        irq_en_ff <= bus_req.wdata[rtc_pkg::IRQ_W-1:0];
      end
      // an event in the clearing cycle stays set
      if (wr && bus_req.addr == rtc_pkg::A_IRQ_CL) begin
        irq_st_ff <= (irq_st_ff & ~bus_req.wdata[rtc_pkg::IRQ_W-1:0]) | ev;
      end else begin
        irq_st_ff <= irq_st_ff | ev;
      end
      irq <= |(irq_st_ff & irq_en_ff);
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else if (clk_en) begin
      // read data stand for one cycle only
      rd_data <= '0;
      if (rd) begin
        unique case (bus_req.addr)
          rtc_pkg::A_MEAS:   rd_data <= 32'(meas_ff);
          rtc_pkg::A_THR1:   rd_data <= 32'(first_threshold_ff);
          rtc_pkg::A_THR2:   rd_data <= 32'(second_threshold_ff);
          rtc_pkg::A_HYSTERESIS_WIDTH:   rd_data <= 32'(hysteresis_width_ff);
          rtc_pkg::A_CTRL:   rd_data <= 32'({cfg_ff.unit_min, cfg_ff.fault,
                                             cfg_ff.mode});
          rtc_pkg::A_TON:    rd_data <= 32'(turn_on_delay_ff);
          rtc_pkg::A_TURN_OFF_DELAY:   rd_data <= 32'(turn_off_delay_ff);
          rtc_pkg::A_TMO:    rd_data <= 32'(link_silence_timeout_ff);
          rtc_pkg::A_BUSCMD: rd_data <= 32'(bus_cmd_ff);
          rtc_pkg::A_STAT:   rd_data <= 32'({crit_now, rng_sync_ff[1],
                                             relay_coil});
          rtc_pkg::A_IRQ_ST: rd_data <= 32'(irq_st_ff);
          rtc_pkg::A_IRQ_EN: rd_data <= 32'(irq_en_ff);
          default:           rd_data <= 32'h0;
        endcase
      end
    end
  end

endmodule // rtc_relay

// ### rtc_relay_checker.sv
// concurrent checks on the relay threshold block
// assumes it is bound to rtc_relay and sees only that module's ports
module rtc_relay_checker (
  input wire logic                  ref_clk,
  input wire logic                  sys_rst,
  input wire logic                  clk_en,
  input wire rtc_pkg::rtc_bus_req_t bus_req,
  input wire logic [31:0]           rd_data,
  input wire logic                  range_ok_pin,
  input wire logic                  link_rx,
  input wire logic                  relay_coil,
  input wire logic                  relay_led,
  input wire logic                  irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // shadow of configuration writes
  // ----------------------------------------
  logic [2:0] mode_ff;
  logic [1:0] fault_ff;
  logic       cmd_ff;
  logic [2:0] en_ff;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_ff  <= rtc_pkg::M_DIS;
      fault_ff <= rtc_pkg::FR_HOLD;
      cmd_ff   <= 1'b0;
      en_ff    <= 3'h0;
    end else if (clk_en && bus_req.wr) begin
      if (bus_req.addr == rtc_pkg::A_CTRL) begin
        mode_ff  <= bus_req.wdata[2:0];
        fault_ff <= bus_req.wdata[4:3];
      end
      if (bus_req.addr == rtc_pkg::A_BUSCMD) cmd_ff <= bus_req.wdata[0];
      if (bus_req.addr == rtc_pkg::A_IRQ_EN) en_ff <= bus_req.wdata[2:0];
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  led_follow_a: assert property (relay_led == relay_coil)
    else $error("led differs from coil");
  dis_off_a: assert property (mode_ff == rtc_pkg::M_DIS &&
    fault_ff == rtc_pkg::FR_OFF |=> !relay_coil) else $error("coil on");
  force_on_a: assert property ((mode_ff == rtc_pkg::M_DIS &&
    fault_ff == rtc_pkg::FR_ON && !range_ok_pin) [*5] |=> relay_coil)
    else $error("force-on missing");
  bus_on_a: assert property (mode_ff == rtc_pkg::M_BUS && cmd_ff &&
    fault_ff == rtc_pkg::FR_ON |=> relay_coil) else $error("bus on lost");
  bus_off_a: assert property (mode_ff == rtc_pkg::M_BUS && !cmd_ff &&
    fault_ff == rtc_pkg::FR_OFF |=> !relay_coil) else $error("bus off lost");
  rd_idle_a: assert property (clk_en && !bus_req.rd |=> rd_data == 32'h0)
    else $error("read data not idle");
  status_rd_a: assert property (clk_en && bus_req.rd &&
    bus_req.addr == rtc_pkg::A_STAT |=> rd_data[0] == $past(relay_coil)
    && rd_data[31:3] == 29'h0) else $error("status read wrong");
  irq_mask_a: assert property (en_ff == 3'h0 |=> !irq)
    else $error("masked interrupt raised");
  reset_out_a: assert property (disable iff (1'b0)
    sys_rst |=> !relay_coil && !irq && rd_data == 32'h0)
    else $error("outputs active in reset");
  cover property ($rose(relay_coil));
  cover property ($rose(irq));
  cover property (mode_ff == rtc_pkg::M_BUS && relay_coil);
endmodule // rtc_relay_checker

// ### rtc_relay_tb.sv
// self-checking bench for the relay threshold block
// assumes rtc_pkg, the checker and the far side model are compiled first
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  mismatches++; $display("FAIL %s exp %0h got %0h", nm, ex, got); end end
module rtc_relay_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  ref_clk, sys_rst, clk_en, range_want, link_on;
  rtc_pkg::rtc_bus_req_t bus_req;
  logic [31:0]           rd_data, rv, lf;
  logic                  range_ok_pin, link_rx, relay_coil, relay_led, irq;
  logic                  seen_on, seen_off;
  int                    mismatches, compares, cycles, mdl, p, t1, t2, h;
  int                    m, lo, hi;
  rtc_relay dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .bus_req(bus_req), .rd_data(rd_data), .range_ok_pin(range_ok_pin),
    .link_rx(link_rx), .relay_coil(relay_coil), .relay_led(relay_led),
    .irq(irq));
  rtc_far_end far (.ref_clk(ref_clk), .sys_rst(sys_rst), .link_on(link_on),
    .range_want(range_want), .link_rx(link_rx), .range_ok_pin(range_ok_pin));
  always #4 ref_clk = ~ref_clk;
  // ----------------------------------------
  // model and bus tasks
  // ----------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic int nxt_coil(int md, int pv);
    int up, dn;
    up = 0;
    dn = 0;
    case (md)
      1: begin up = m > t1 + h; dn = m < t1 - h; end
      2: begin up = m < t1 - h; dn = m > t1 + h; end
      3: begin up = m > lo + h && m < hi - h; dn = m < lo - h || m > hi + h; end
      4: begin up = m > hi + h || m < lo - h; dn = m > lo + h && m < hi - h; end
      default: ;
    endcase
    return up ? 1 : dn ? 0 : pv;
  endfunction
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge ref_clk);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 rv = rd_data;
  endtask
  task automatic ctl(int md, int fr);
    wr(rtc_pkg::A_CTRL, 32'(md + fr * 8));
  endtask
  task automatic chk_coil(int e);
    repeat (8) @(posedge ref_clk);
    #1;
    `CHK("coil", e[0], relay_coil)
    `CHK("led", e[0], relay_led)
  endtask
  task automatic end_sim;
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    ref_clk = 0; sys_rst = 1; clk_en = 1; bus_req = '0; range_want = 1;
    link_on = 0; lf = 32'h61ad; mdl = 0; m = 0; h = 8;
    seen_on = 0; seen_off = 0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 16; a++) if (a < 9 || a > 12) begin
      rd(a[3:0]);
      `CHK("reset read", 32'h0, rv)
    end
    wr(rtc_pkg::A_IRQ_EN, 32'h0);
    for (int md = 1; md <= 4; md++) begin
      ctl(0, 0);
      if (mdl != 0) seen_off = 1;
      mdl = 0;
      lf = lfsr(lf);
      t1 = 200 + lf[7:0];
      t2 = lf[8] ? t1 + 60 + lf[15:9] : t1 - 60 - lf[15:9];
      lo = t1 < t2 ? t1 : t2;
      hi = t1 < t2 ? t2 : t1;
      wr(rtc_pkg::A_THR1, 32'(t1));
      wr(rtc_pkg::A_THR2, 32'(t2));
      wr(rtc_pkg::A_HYSTERESIS_WIDTH, 32'(h));
      ctl(md, 0);
      for (int k = 0; k < 25; k++) begin
        if (k > 0) begin
          lf = lfsr(lf);
          m = lf[9:0];
          wr(rtc_pkg::A_MEAS, 32'(m));
        end
        p = mdl;
        mdl = nxt_coil(md, mdl);
        if (mdl > p) seen_on = 1;
        if (mdl < p) seen_off = 1;
        chk_coil(mdl);
      end
    end
    rd(rtc_pkg::A_IRQ_ST);
    `CHK("irq status", {1'b0, seen_off, seen_on}, rv[2:0])
    `CHK("irq masked", 1'b0, irq)
    wr(rtc_pkg::A_IRQ_EN, 32'h1);
    chk_coil(mdl);
    `CHK("irq", seen_on, irq)
    wr(rtc_pkg::A_IRQ_CL, 32'h7);
    chk_coil(mdl);
    `CHK("irq cleared", 1'b0, irq)
    ctl(0, 2);
    chk_coil(0);
    ctl(0, 1);
    range_want = 0;
    chk_coil(1);
    rd(rtc_pkg::A_STAT);
    `CHK("status", 3'h5, rv[2:0])
    range_want = 1;
    chk_coil(0);
    t1 = 100;
    wr(rtc_pkg::A_THR1, 32'h64);
    wr(rtc_pkg::A_HYSTERESIS_WIDTH, 32'h0);
    wr(rtc_pkg::A_MEAS, 32'h1f4);
    ctl(1, 0);
    chk_coil(1);
    range_want = 0;
    chk_coil(1);
    wr(rtc_pkg::A_MEAS, 32'h0);
    chk_coil(1);
    ctl(1, 2);
    chk_coil(0);
    range_want = 1;
    wr(rtc_pkg::A_MEAS, 32'h1f4);
    link_on = 1;
    ctl(5, 1);
    wr(rtc_pkg::A_BUSCMD, 32'h1);
    chk_coil(1);
    ctl(5, 2);
    wr(rtc_pkg::A_BUSCMD, 32'h0);
    chk_coil(0);
    ctl(5, 0);
    wr(rtc_pkg::A_BUSCMD, 32'h1);
    chk_coil(1);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk_coil(0);
    rd(rtc_pkg::A_BUSCMD);
    `CHK("bus command", 32'h0, rv)
    wr(rtc_pkg::A_TON, 32'h3ff);
    rd(rtc_pkg::A_TON);
    `CHK("delay clamp", 32'h3e7, rv)
    wr(rtc_pkg::A_THR1, 32'h64);
    wr(rtc_pkg::A_MEAS, 32'h1f4);
    ctl(1, 0);
    repeat (1000) @(posedge ref_clk);
    chk_coil(0);
    end_sim();
  end
endmodule // rtc_relay_tb
bind rtc_relay rtc_relay_checker chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .clk_en(clk_en), .bus_req(bus_req), .rd_data(rd_data),
  .range_ok_pin(range_ok_pin), .link_rx(link_rx), .relay_coil(relay_coil),
  .relay_led(relay_led), .irq(irq));
